/* sec_pkg.sv */
// Constants, types and helpers of the serial EEPROM command logic
// Notes on behaviour
// R1: Status: pin protect 7, zeros 6..4, block protect 3..2, latch 1, busy 0.
// R2: Block-protect bits change only by status write; kept nonvolatile. Here srst also clears them to 0.
// R3: Latch set and cleared by its own commands; cleared at power-up.
// R4: Busy is 1 during a self-timed write, 0 when ready; not writable.
// R5: Protect pin ignored when pin-protect enable is 0, honoured when 1.
// R6: Array writes refused in the block-protect range; reads still allowed.
// R7: Protect pin low with enable set rejects status write, never array write.
// R8: A started self-timed write completes whatever the protect pin does.
// R9: Pause pin moves with clock low; low freezes transfer, high resumes it.
// R10: Opcodes 06h/04h set/clear latch, 03h/02h read/write, 05h/01h status.
// R11: Latch commands act at rise 7 counted from 0; later clocks harmless.
// R12: Array or status write with the latch cleared is discarded.
// R13: An executed write clears the write latch automatically.
// R14: Read data driven from the falling edge after the address, MSB first.
// R15: Continued read clocks advance the address, wrapping from top to zero.
// R16: Write takes opcode, address, data; programs from select rise, in 5ms.
// R17: While programming, every command except status read is ignored.
// R18: Select rise after last data bit, before next rise; else write abandoned.
// R19: Up to 32 data bytes per write, all programmed in one self-timed cycle.
// R20: Page write steps only the low 5 address bits, wrapping in the page.
// R21: Input sampled at rising edges, output changed at falling, MSB first.
// R22: While paused, clock and input are ignored, output high impedance.
// R23: Select high while paused resets the command state; no resume after.
// R24: Read and write take a 16-bit address; only the low 12 bits are used.
// R25: Output off while deselected; each select fall restarts the opcode.
package sec_pkg;

  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_ARRAY        = 8'h03;
  localparam logic [7:0] OP_WRITE_ARRAY       = 8'h02;
  localparam logic [7:0] OP_READ_STATUS       = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS      = 8'h01;

  localparam int unsigned STAT_PIN_PROTECT_BIT = 7;
  localparam int unsigned STAT_BP_HI_BIT       = 3;
  localparam int unsigned STAT_BP_LO_BIT       = 2;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned MEM_DEPTH    = 4096;
  localparam int unsigned PAGE_BYTES   = 32;
  localparam int unsigned PAGE_W       = 5;
  localparam int unsigned OPC_BITS     = 8;
  localparam int unsigned ADDR_FIELD   = 16;
  localparam int unsigned LATCH_EDGE   = 7;

  localparam logic [11:0] PROT_QUARTER_BASE = 12'hC00;
  localparam logic [11:0] PROT_HALF_BASE    = 12'h800;

  localparam int unsigned T_EW_NS        = 5000000;
  localparam int unsigned SYS_PERIOD_NS  = 4;
  localparam int unsigned EW_CYCLES      = T_EW_NS / SYS_PERIOD_NS;
  localparam int unsigned TIMER_W        = 21;

  typedef struct packed {
    logic       pinProtectEnable;
    logic [2:0] zero;
    logic       blockProtectHi;
    logic       blockProtectLo;
    logic       writeLatch;
    logic       busy;
  } sec_status_t;

  localparam sec_status_t STATUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    PH_OPC    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_READ   = 3'b010,
    PH_WDATA  = 3'b011,
    PH_SREAD  = 3'b100,
    PH_SDATA  = 3'b101,
    PH_IGNORE = 3'b110
  } sec_phase_t;

  typedef struct packed {
    sec_phase_t  phase;
    logic [3:0]  cnt;
    logic [2:0]  bitN;
    logic [7:0]  opc;
    logic [15:0] addrSh;
    logic [11:0] addr;
    logic [7:0]  rxSh;
    logic [7:0]  txSh;
    logic        txOn;
    logic        armed;
    logic        armStatus;
    logic [31:0] valid;
    logic [7:0]  statusData;
    logic        setTgl;
    logic        clrTgl;
    logic [7:0]  st1;
    logic [7:0]  st2;
    logic [7:0]  st3;
    sec_status_t stView;
  } sec_link_state_t;

  localparam sec_link_state_t LINK_RESET = '0;

  typedef struct packed {
    logic [2:0]        csSy;
    logic [2:0]        armSy;
    logic [2:0]        pinSy;
    logic [2:0]        setSy;
    logic [2:0]        clrSy;
    logic              csView;
    logic              armView;
    logic              pinView;
    logic              setView;
    logic              clrView;
    sec_status_t       status;
    logic              programming;
    logic [4:0]        idx;
    logic [TIMER_W-1:0] timer;
  } sec_sys_state_t;

  localparam sec_sys_state_t SYS_RESET = '{
    csSy: 3'h7, armSy: 3'h0, pinSy: 3'h7, setSy: 3'h0, clrSy: 3'h0,
    csView: 1'b1, armView: 1'b0, pinView: 1'b1, setView: 1'b0,
    clrView: 1'b0, status: STATUS_RESET, programming: 1'b0,
    idx: 5'h00, timer: '0};

  function automatic logic agree(input logic [2:0] s, input logic v);
    agree = (s[1] == s[2]) ? s[2] : v;
  endfunction

  function automatic logic isProtected(input logic [11:0] a,
                                       input logic [1:0] bp);
    case (bp)
      2'b00:   isProtected = 1'b0;
      2'b01:   isProtected = (a >= PROT_QUARTER_BASE);
      2'b10:   isProtected = (a >= PROT_HALF_BASE);
      default: isProtected = 1'b1;
    endcase
  endfunction

endpackage

/* sec_spi_eeprom.sv */
// Serial EEPROM slave: link-side command decoder and system-side programmer
`timescale 1ns/1ps
module sec_spi_eeprom #(
  parameter int unsigned WRITE_CYCLES = sec_pkg::EW_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic serialClk,
  input  wire logic chipSelectN,
  input  wire logic serialIn,
  input  wire logic pausePinN,
  input  wire logic protectPinN,
  output logic      serialOut,
  output logic      serialOutOeN
);
  import sec_pkg::*;

  logic [7:0]      mem     [0:MEM_DEPTH-1];
  logic [7:0]      pageBuf [0:PAGE_BYTES-1];

  sec_link_state_t l_reg;
  sec_link_state_t l_next;
  sec_sys_state_t  s_reg;
  sec_sys_state_t  s_next;

  logic            frameIdle;
  logic            linkOff;
  logic            pbWe;
  logic [4:0]      pbIdx;
  logic [7:0]      pbData;
  logic            memWe;
  logic [11:0]     memAddr;

  // Frame start marker: raised while select is high
  always_ff @(posedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      frameIdle <= 1'b1; // [R25] [R23]
    end else if (pausePinN) begin
      frameIdle <= 1'b0;
    end
  end

  // Link side next state
  always_comb begin
    sec_link_state_t cur;
    logic [7:0]      byteIn;
    logic [11:0]     a;
    logic [11:0]     nextA;
    logic            busyView;
    cur      = l_reg;
    l_next   = l_reg;
    byteIn   = {l_reg.rxSh[6:0], serialIn};
    a        = {l_reg.addrSh[10:0], serialIn};
    nextA    = l_reg.addr + 12'h001;
    busyView = l_reg.stView.busy;
    pbWe     = 1'b0;
    pbIdx    = l_reg.addr[4:0];
    pbData   = byteIn;
    // Status word brought over from the system side
    l_next.st1 = s_reg.status;
    l_next.st2 = l_reg.st1;
    l_next.st3 = l_reg.st2;
    l_next.stView = (~(l_reg.st2 ^ l_reg.st3) & l_reg.st3)
                  | ((l_reg.st2 ^ l_reg.st3) & l_reg.stView);
    if (frameIdle) begin
      cur.phase = PH_OPC; // [R25]
      cur.cnt   = 4'h0;
      cur.bitN  = 3'h0;
      cur.txOn  = 1'b0;
    end
    if (pausePinN) begin // [R9] [R22]
      l_next.phase     = cur.phase;
      l_next.cnt       = cur.cnt;
      l_next.bitN      = cur.bitN;
      l_next.txOn      = cur.txOn;
      l_next.rxSh      = byteIn; // [R21]
      l_next.armed     = 1'b0; // [R18]
      case (cur.phase)
        PH_OPC: begin
          l_next.cnt = cur.cnt + 4'h1;
          l_next.opc = byteIn;
          // Clock rise 7 counted from zero: the whole opcode is known
          if (cur.cnt == 4'(LATCH_EDGE) && !busyView) begin // [R17]
            if (byteIn == OP_SET_WRITE_LATCH) begin
              l_next.setTgl = ~l_reg.setTgl; // [R11] [R3]
            end
            if (byteIn == OP_CLEAR_WRITE_LATCH) begin
              l_next.clrTgl = ~l_reg.clrTgl; // [R11] [R3]
            end
          end
          if (cur.cnt == 4'(OPC_BITS - 1)) begin
            l_next.cnt = 4'h0;
            if (busyView && byteIn != OP_READ_STATUS) begin
              l_next.phase = PH_IGNORE; // [R17]
            end else begin
              case (byteIn) // [R10]
                OP_READ_ARRAY: begin
                  l_next.phase = PH_ADDR;
                end
                OP_WRITE_ARRAY: begin
                  l_next.phase = PH_ADDR;
                  l_next.valid = 32'h0000_0000;
                end
                OP_READ_STATUS: begin
                  l_next.phase = PH_SREAD;
                  l_next.txSh  = l_reg.stView; // [R1]
                  l_next.txOn  = 1'b1;
                  l_next.bitN  = 3'h0;
                end
                OP_WRITE_STATUS: begin
                  l_next.phase = PH_SDATA;
                  l_next.bitN  = 3'h0;
                end
                default: begin
                  l_next.phase = PH_IGNORE; // [R11]
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          l_next.cnt    = cur.cnt + 4'h1;
          l_next.addrSh = {l_reg.addrSh[14:0], serialIn};
          if (cur.cnt == 4'(ADDR_FIELD - 1)) begin
            l_next.addr = a; // [R24]
            l_next.bitN = 3'h0;
            if (l_reg.opc == OP_READ_ARRAY) begin
              l_next.phase = PH_READ;
              l_next.txSh  = mem[a]; // [R14]
              l_next.txOn  = 1'b1;
            end else begin
              l_next.phase = PH_WDATA;
            end
          end
        end
        PH_READ: begin
          l_next.bitN = cur.bitN + 3'h1;
          if (cur.bitN == 3'h7) begin
            l_next.addr = nextA; // [R15]
            l_next.txSh = mem[nextA];
          end else begin
            l_next.txSh = {l_reg.txSh[6:0], 1'b0}; // [R14]
          end
        end
        PH_SREAD: begin
          l_next.bitN = cur.bitN + 3'h1;
          if (cur.bitN == 3'h7) begin
            l_next.txSh = l_reg.stView;
          end else begin
            l_next.txSh = {l_reg.txSh[6:0], 1'b0};
          end
        end
        PH_WDATA: begin
          l_next.bitN = cur.bitN + 3'h1;
          if (cur.bitN == 3'h7) begin
            pbWe                    = 1'b1; // [R19]
            l_next.valid[pbIdx]     = 1'b1;
            l_next.addr             = {l_reg.addr[11:5],
                                       l_reg.addr[4:0] + 5'h01}; // [R20]
            l_next.armed            = 1'b1; // [R18]
            l_next.armStatus        = 1'b0;
          end
        end
        PH_SDATA: begin
          l_next.bitN = cur.bitN + 3'h1;
          if (cur.bitN == 3'h7) begin
            l_next.statusData = byteIn;
            l_next.armed      = 1'b1; // [R18]
            l_next.armStatus  = 1'b1;
            l_next.phase      = PH_IGNORE;
          end
        end
        default: begin
          l_next.txOn = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge serialClk or posedge srst) begin
    if (srst) begin
      l_reg <= LINK_RESET;
    end else begin
      l_reg <= l_next;
    end
  end

  always_ff @(posedge serialClk) begin
    if (pbWe) begin
      pageBuf[pbIdx] <= pbData; // [R20]
    end
  end

  // Output pin changes at falling edges; released when deselected or paused
  assign linkOff = chipSelectN | ~pausePinN;

  always_ff @(negedge serialClk or posedge linkOff) begin
    if (linkOff) begin
      serialOut    <= 1'b0;
      serialOutOeN <= 1'b1; // [R22] [R25]
    end else begin
      serialOut    <= l_reg.txSh[7]; // [R21]
      serialOutOeN <= ~(l_reg.txOn & ~frameIdle);
    end
  end

  // System side next state: latch, protection and self-timed programming
  always_comb begin
    logic csRise;
    logic pinLow;
    csRise = 1'b0;
    pinLow = 1'b0;
    s_next = s_reg;
    memWe  = 1'b0;
    memAddr = {l_reg.addr[11:5], s_reg.idx};
    s_next.csSy    = {s_reg.csSy[1:0], chipSelectN};
    s_next.armSy   = {s_reg.armSy[1:0], l_reg.armed};
    s_next.pinSy   = {s_reg.pinSy[1:0], protectPinN};
    s_next.setSy   = {s_reg.setSy[1:0], l_reg.setTgl};
    s_next.clrSy   = {s_reg.clrSy[1:0], l_reg.clrTgl};
    s_next.csView  = agree(s_reg.csSy, s_reg.csView);
    s_next.armView = agree(s_reg.armSy, s_reg.armView);
    s_next.pinView = agree(s_reg.pinSy, s_reg.pinView);
    s_next.setView = agree(s_reg.setSy, s_reg.setView);
    s_next.clrView = agree(s_reg.clrSy, s_reg.clrView);
    csRise = s_next.csView & ~s_reg.csView;
    pinLow = s_reg.status.pinProtectEnable & ~s_reg.pinView; // [R5]
    if (!s_reg.status.busy) begin
      if (s_next.setView != s_reg.setView) begin
        s_next.status.writeLatch = 1'b1; // [R3]
      end
      if (s_next.clrView != s_reg.clrView) begin
        s_next.status.writeLatch = 1'b0; // [R3]
      end
    end
    if (s_reg.status.busy) begin
      if (s_reg.programming) begin
        memWe = l_reg.valid[s_reg.idx]
              & ~isProtected(memAddr, {s_reg.status.blockProtectHi,
                                       s_reg.status.blockProtectLo}); // [R6]
        s_next.idx = s_reg.idx + 5'h01;
        if (s_reg.idx == 5'(PAGE_BYTES - 1)) begin
          s_next.programming = 1'b0; // [R19]
        end
      end
      s_next.timer = s_reg.timer + TIMER_W'(1);
      if (s_reg.timer == TIMER_W'(WRITE_CYCLES - 1)) begin
        s_next.timer       = '0;
        s_next.status.busy = 1'b0; // [R4] [R8] [R16]
      end
    end else if (csRise && s_reg.armView && s_reg.status.writeLatch) begin
      if (l_reg.armStatus) begin
        if (!pinLow) begin // [R7]
          s_next.status.busy             = 1'b1; // [R4]
          s_next.status.writeLatch       = 1'b0; // [R13]
          s_next.status.pinProtectEnable =
            l_reg.statusData[STAT_PIN_PROTECT_BIT];
          s_next.status.blockProtectHi   =
            l_reg.statusData[STAT_BP_HI_BIT]; // [R2]
          s_next.status.blockProtectLo   =
            l_reg.statusData[STAT_BP_LO_BIT];
        end
      end else begin
        s_next.status.busy       = 1'b1; // [R16]
        s_next.status.writeLatch = 1'b0; // [R13]
        s_next.programming       = 1'b1;
        s_next.idx               = 5'h00;
      end
    end
    s_next.status.zero = 3'h0; // [R1]
  end

  // Write latch guard: starts above need writeLatch set [R12]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= SYS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[memAddr] <= pageBuf[s_reg.idx]; // [R19]
    end
  end

endmodule

/* sec_host_model.sv */
// Host SPI controller model that drives the link pins of the EEPROM
`timescale 1ns/1ps
module sec_host_model (
  output logic      serialClk,
  output logic      chipSelectN,
  output logic      serialIn,
  output logic      pausePinN,
  input  wire logic serialOut,
  input  wire logic serialOutOeN
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int         pauseAt = -1;
  logic       heldOe;
  logic       lineIn;
  // A released output line is never trusted
  assign lineIn = serialOutOeN ? 1'bx : serialOut;
  initial begin
    serialClk = 1'b0;
    serialIn = 1'b0;
    pausePinN = 1'b1;
    // Late select edge gives the pin-forced resets a clean event
    #1 chipSelectN = 1'b1;
  end
  // Pause while the clock is low, give one stray clock meanwhile
  task automatic pause();
    pausePinN = 1'b0;
    serialIn = ~serialIn;
    #12 serialClk = 1'b1;
    heldOe = serialOutOeN;
    #12 serialClk = 1'b0;
    #12 pausePinN = 1'b1;
  endtask
  // One frame: up to nbits bits of txq, answers gathered in rxq
  task automatic run(input int nbits);
    int         k;
    logic [7:0] r;
    k = 0;
    r = 8'h00;
    rxq.delete();
    #1 chipSelectN = 1'b0;
    #24;
    foreach (txq[j]) begin
      for (int i = 7; i >= 0; i--) begin
        if (k < nbits) begin
          if (j == pauseAt && i == 7) pause();
          serialIn = txq[j][i];
          #24 serialClk = 1'b1;
          r[i] = lineIn;
          #24 serialClk = 1'b0;
          k++;
        end
      end
      rxq.push_back(r);
    end
    #12 chipSelectN = 1'b1;
    #39;
  endtask
endmodule

/* sec_spi_eeprom_monitor.sv */
// Concurrent checks on the link pins of the serial EEPROM
`timescale 1ns/1ps
module sec_spi_eeprom_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic pausePinN,
  input wire logic protectPinN,
  input wire logic serialOut,
  input wire logic serialOutOeN
);
  import sec_pkg::*;
  logic [4:0] bitCnt;
  logic [7:0] opcode;
  // Frame edge count; wraps 31 to 24 so the low bits keep byte phase
  always_ff @(posedge serialClk or posedge chipSelectN or posedge srst) begin
    if (chipSelectN || srst) begin
      bitCnt <= 5'h00;
      opcode <= 8'h00;
    end else if (pausePinN) begin
      bitCnt <= (bitCnt == 5'h1F) ? 5'h18 : bitCnt + 5'h01;
      if (bitCnt < 5'h08) opcode <= {opcode[6:0], serialIn};
    end
  end
  sequence s_stat_out;
    !chipSelectN && pausePinN && bitCnt >= 5'h08 && opcode == OP_READ_STATUS;
  endsequence
  sequence s_stat_zero;
    s_stat_out ##0 (bitCnt[2:0] inside {3'h1, 3'h2, 3'h3});
  endsequence
  a_desel_quiet: assert property (
    @(posedge sys_clk) disable iff (srst) chipSelectN |-> serialOutOeN)
    else $error("Output driven while deselected");
  a_pause_quiet: assert property (
    @(posedge sys_clk) disable iff (srst) !pausePinN |-> serialOutOeN)
    else $error("Output driven while paused");
  a_out_on_fall: assert property (
    @(posedge sys_clk) disable iff (srst)
    !chipSelectN && $changed(serialOut) |-> !serialClk)
    else $error("Output changed while clock high");
  a_opcode_quiet: assert property (
    @(posedge serialClk) disable iff (srst)
    !chipSelectN && bitCnt < 5'h08 |-> serialOutOeN)
    else $error("Output driven during opcode");
  a_status_drive: assert property (
    @(posedge serialClk) disable iff (srst) s_stat_out |-> !serialOutOeN)
    else $error("Status not driven");
  a_status_zeros: assert property (
    @(posedge serialClk) disable iff (srst) s_stat_zero |-> !serialOut)
    else $error("Status bits 6 to 4 not zero");
  a_read_late: assert property (
    @(posedge serialClk) disable iff (srst)
    opcode == OP_READ_ARRAY && bitCnt == 5'h08 |->
    serialOutOeN [*8] ##1 serialOutOeN [*8])
    else $error("Read data before address end");
  a_write_silent: assert property (
    @(posedge serialClk) disable iff (srst) !chipSelectN && bitCnt >= 5'h08
    && opcode inside {8'h01, 8'h02, 8'h04, 8'h06} |-> serialOutOeN)
    else $error("Output driven in a write frame");
endmodule

bind sec_spi_eeprom sec_spi_eeprom_monitor u_sec_spi_eeprom_monitor (
  .sys_clk(sys_clk), .srst(srst), .serialClk(serialClk),
  .chipSelectN(chipSelectN), .serialIn(serialIn), .pausePinN(pausePinN),
  .protectPinN(protectPinN), .serialOut(serialOut),
  .serialOutOeN(serialOutOeN));

/* testbench.sv */
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
module testbench;
  import sec_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b0;
  logic        protectPinN = 1'b0;
  logic        serialClk, chipSelectN, serialIn, pausePinN;
  logic        serialOut, serialOutOeN;
  logic [7:0]  st, v, pg[$], m[3], m32[32];
  logic [15:0] pa[3] = '{16'h07FF, 16'h0800, 16'h0C00};
  int          n_mismatch = 0;
  int          compares = 0;
  always #2 sys_clk = ~sys_clk;
  sec_spi_eeprom #(.WRITE_CYCLES(400)) u_sec_spi_eeprom (
    .sys_clk(sys_clk), .srst(srst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialIn(serialIn), .pausePinN(pausePinN),
    .protectPinN(protectPinN), .serialOut(serialOut),
    .serialOutOeN(serialOutOeN));
  sec_host_model u_sec_host_model (
    .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .pausePinN(pausePinN), .serialOut(serialOut),
    .serialOutOeN(serialOutOeN));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] rx(input int i);
    return u_sec_host_model.rxq[i];
  endfunction
  function automatic logic prot(input logic [15:0] a, input int bp);
    return bp == 3 || (bp == 2 && a[11:0] >= 12'h800) ||
      (bp == 1 && a[11:0] >= 12'hC00);
  endfunction
  task automatic xfer(input logic [7:0] b[$], input int nbits);
    u_sec_host_model.txq = b;
    u_sec_host_model.run(nbits);
  endtask
  task automatic status(output logic [7:0] s);
    xfer({OP_READ_STATUS, 8'h00}, 16);
    s = rx(1);
  endtask
  task automatic latch();
    xfer({OP_SET_WRITE_LATCH, 8'h00}, 16);
  endtask
  task automatic ready();
    for (int i = 0; i < 60; i++) begin
      status(st);
      if (st[0] === 1'b0) return;
    end
    n_mismatch++;
    $display("MISMATCH %0t busy never cleared", $time);
    conclude();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    latch();
    xfer({OP_WRITE_ARRAY, a[15:8], a[7:0], d}, 24 + 8 * d.size());
    ready();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] q[$];
    q = {OP_READ_ARRAY, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) q.push_back(8'h00);
    xfer(q, 8 * q.size());
  endtask
  task automatic wsr(input logic [7:0] s);
    latch();
    xfer({OP_WRITE_STATUS, s}, 16);
  endtask
  initial begin
    @(negedge sys_clk) srst = 1'b1;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    status(st);
    chk(st, 8'h00);
    latch();
    status(st);
    chk(st, 8'h02);
    xfer({OP_CLEAR_WRITE_LATCH}, 8);
    status(st);
    chk(st, 8'h00);
    xfer({OP_WRITE_ARRAY, 8'h00, 8'h10, 8'h55}, 32);
    status(st);
    chk(st, 8'h00);
    for (int i = 0; i < 34; i++) pg.push_back(8'h40 + i[7:0]);
    latch();
    xfer({OP_WRITE_ARRAY, 8'hF0, 8'h3C, pg}, 24 + 8 * 34);
    status(st);
    chk(st, 8'h01);
    latch();
    ready();
    status(st);
    chk(st, 8'h00);
    rd(16'h0020, 32);
    for (int i = 0; i < 34; i++) m32[(28 + i) % 32] = 8'h40 + i[7:0];
    for (int i = 0; i < 32; i++) chk(rx(3 + i), m32[i]);
    wr(16'h0FFF, {8'h5A});
    wr(16'h0000, {8'hA5});
    u_sec_host_model.pauseAt = 2;
    rd(16'h0FFF, 2);
    u_sec_host_model.pauseAt = -1;
    chk(rx(3), 8'h5A);
    chk(rx(4), 8'hA5);
    chk({7'h00, u_sec_host_model.heldOe}, 8'h01);
    for (int bp = 0; bp < 4; bp++) begin
      wsr({4'h0, bp[1:0], 2'b00});
      ready();
      status(st);
      chk(st, {4'h0, bp[1:0], 2'b00});
      for (int j = 0; j < 3; j++) begin
        v = {bp[3:0], j[3:0]};
        wr(pa[j], {v});
        if (!prot(pa[j], bp)) m[j] = v;
        rd(pa[j], 1);
        chk(rx(3), m[j]);
      end
    end
    @(negedge sys_clk) protectPinN = 1'b1;
    wsr(8'h80);
    ready();
    @(negedge sys_clk) protectPinN = 1'b0;
    wsr(8'h0C);
    status(st);
    chk(st, 8'h82);
    wr(16'h0100, {8'h3C});
    rd(16'h0100, 1);
    chk(rx(3), 8'h3C);
    @(negedge sys_clk) protectPinN = 1'b1;
    wsr(8'h00);
    #40;
    @(negedge sys_clk) protectPinN = 1'b0;
    ready();
    status(st);
    chk(st, 8'h00);
    latch();
    xfer({OP_WRITE_ARRAY, 8'h01, 8'h00, 8'h99}, 28);
    status(st);
    chk({7'h00, st[0]}, 8'h00);
    rd(16'h0100, 1);
    chk(rx(3), 8'h3C);
    conclude();
  end
endmodule
